//--- include/lmsc_regs.vh
// Register offsets, field positions, reset values and decode constants of the stack and current block
`ifndef LMSC_REGS_VH
`define LMSC_REGS_VH

// Word addresses on the Avalon-MM slave (byte address / 4)
`define LMSC_ADDR_W 3
`define LMSC_OFS_STACK 3'h0
`define LMSC_OFS_GAIN 3'h1
`define LMSC_OFS_COLOR 3'h2
`define LMSC_OFS_STATUS 3'h3
`define LMSC_OFS_ID 3'h4

// Stack control word fields
`define LMSC_STACK_SIZE_LSB 0
`define LMSC_STACK_SIZE_MSB 2
`define LMSC_STACK_REV_BIT 4
`define LMSC_STACK_POS_LSB 8
`define LMSC_STACK_POS_MSB 9
`define LMSC_STACK_LINES_LSB 16
`define LMSC_STACK_LINES_MSB 20

// Colour word fields
`define LMSC_RED_LSB 0
`define LMSC_RED_MSB 7
`define LMSC_GRN_LSB 8
`define LMSC_GRN_MSB 15
`define LMSC_BLU_LSB 16
`define LMSC_BLU_MSB 23

// Reset values
`define LMSC_SIZE_RST 3'h0
`define LMSC_GAIN_RST 3'h3
`define LMSC_COLOR_RST 8'h7f
`define LMSC_LINES_RST 5'h10
`define LMSC_POS_RST 2'h0

// Stack size codes
`define LMSC_SIZE_INDEP 3'h0
`define LMSC_SIZE_2SEQ 3'h1
`define LMSC_SIZE_48_123 3'h2
`define LMSC_SIZE_48_132 3'h3
`define LMSC_SIZE_4864_123 3'h4
`define LMSC_SIZE_4864_132 3'h5
`define LMSC_SIZE_64_1234 3'h6
`define LMSC_SIZE_64_143 3'h7

// Line geometry
`define LMSC_SWITCHES 16
`define LMSC_SW_MAX 4'hf
`define LMSC_SW_ZERO 4'h0
`define LMSC_SW_ONE 4'h1
`define LMSC_LINES_PER_DEV 7'h10

// Gain table in hundredths
`define LMSC_GAIN_0 16'd2417
`define LMSC_GAIN_1 16'd3057
`define LMSC_GAIN_2 16'd4949
`define LMSC_GAIN_3 16'd8661
`define LMSC_GAIN_4 16'd10394
`define LMSC_GAIN_5 16'd12992
`define LMSC_GAIN_6 16'd14848
`define LMSC_GAIN_7 16'd17323

// Identity word, arbitrary value
`define LMSC_ID_VALUE 32'h1a5c0001

`endif

//--- verilog/lmsc_line_stepper.v
// Row switch stepper: one-hot row switch drive in ascending or descending order
`timescale 1ns/1ps
`include "lmsc_regs.vh"
module lmsc_line_stepper (
  input wire clock,
  input wire rst,
  input wire ce,
  input wire enable,
  input wire advance,
  input wire reverse,
  input wire [4:0] usedLines,
  output reg [15:0] rowSwitch,
  output reg [3:0] switchIndex,
  output reg [3:0] lineIndex,
  output reg frameWrap
);

  reg [3:0] lineIndex_d;
  reg wrap_d;
  reg [4:0] lastLine;

  // Last used line, unused switches are the highest line positions
  always @*
  begin
    if (usedLines == 5'h0 || usedLines > 5'h10)
      lastLine = 5'h10;
    else
      lastLine = usedLines;
  end

  // Next line position inside this device
  always @*
  begin
    wrap_d = 1'b0;
    lineIndex_d = lineIndex;
    if (advance)
    begin
      if ({1'b0, lineIndex} + 5'h1 >= lastLine)
      begin
        lineIndex_d = `LMSC_SW_ZERO;
        wrap_d = 1'b1;
      end
      else
        lineIndex_d = lineIndex + `LMSC_SW_ONE;
    end
  end

  // Line position to switch number, descending when reversed
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      lineIndex <= 4'h0;
      switchIndex <= 4'h0;
      rowSwitch <= 16'h0;
      frameWrap <= 1'b0;
    end
    else if (ce)
    begin
      lineIndex <= enable ? lineIndex_d : `LMSC_SW_ZERO;
      frameWrap <= enable & wrap_d;
      switchIndex <= reverse ? (`LMSC_SW_MAX - lineIndex) : lineIndex;
      rowSwitch <= enable ? (16'h1 << (reverse ? (`LMSC_SW_MAX - lineIndex) : lineIndex)) : 16'h0;
    end
  end

endmodule

//--- verilog/lmsc_gain_decode.v
// Current code decoder: global gain and colour ratio numerators
`timescale 1ns/1ps
`include "lmsc_regs.vh"
module lmsc_gain_decode (
  input wire clock,
  input wire rst,
  input wire ce,
  input wire [2:0] globalGainCode,
  input wire [7:0] colorCode,
  output reg [15:0] gainHundredths,
  output reg [8:0] ratioNum
);

  // Gain step in hundredths for one code
  function [15:0] gainOf;
    input [2:0] code;
    begin
      case (code)
        3'h0: gainOf = `LMSC_GAIN_0;
        3'h1: gainOf = `LMSC_GAIN_1;
        3'h2: gainOf = `LMSC_GAIN_2;
        3'h3: gainOf = `LMSC_GAIN_3;
        3'h4: gainOf = `LMSC_GAIN_4;
        3'h5: gainOf = `LMSC_GAIN_5;
        3'h6: gainOf = `LMSC_GAIN_6;
        default: gainOf = `LMSC_GAIN_7;
      endcase
    end
  endfunction

  // Registered decode, ratio is (code+1)/256
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      gainHundredths <= `LMSC_GAIN_3;
      ratioNum <= 9'h80;
    end
    else if (ce)
    begin
      gainHundredths <= gainOf(globalGainCode);
      ratioNum <= {1'b0, colorCode} + 9'h1;
    end
  end

endmodule

//--- verilog/lmsc_stack_current.v
// Stack mode, scan order and current code block with an Avalon-MM register slave
//
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "lmsc_regs.vh"
module lmsc_stack_current (
  input wire clock,
  input wire rst,
  input wire ce,
  input wire [2:0] avsAddress,
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsWritedata,
  input wire [3:0] avsByteenable,
  output reg [31:0] avsReaddata,
  output reg avsWaitrequest,
  output reg [1:0] avsResponse,
  input wire lineAdvance,
  output reg [15:0] rowSwitch,
  output reg [6:0] matrixLine,
  output reg lineOwned,
  output reg [15:0] globalGain,
  output reg [8:0] redRatio,
  output reg [8:0] greenRatio,
  output reg [8:0] blueRatio,
  output reg [2:0] deviceCount
);

  localparam ST_IDLE = 2'h0;
  localparam ST_ACK = 2'h1;

  reg [1:0] busState_q;
  reg [2:0] stackSize_q;
  reg scanReverse_q;
  reg [1:0] stackPos_q;
  reg [4:0] usedLines_q;
  reg [2:0] gainCode_q;
  reg [7:0] redCode_q;
  reg [7:0] greenCode_q;
  reg [7:0] blueCode_q;
  reg [2:0] slot_d;
  reg [2:0] devices_d;
  reg [31:0] readWord_d;
  reg mapped_d;
  reg owned_q;
  reg [2:0] turn_q;
  wire [15:0] stepSwitch;
  wire [3:0] stepIndex;
  wire [3:0] stepLine;
  wire stepLast;
  wire [15:0] gainValue;
  wire [8:0] ratioR;
  wire [8:0] ratioG;
  wire [8:0] ratioB;

  // Devices taking part for each stack size code
  function [2:0] devicesOf;
    input [2:0] size;
    begin
      case (size)
        `LMSC_SIZE_INDEP: devicesOf = 3'h1;
        `LMSC_SIZE_2SEQ: devicesOf = 3'h2;
        `LMSC_SIZE_48_123, `LMSC_SIZE_48_132, `LMSC_SIZE_4864_123, `LMSC_SIZE_4864_132: devicesOf = 3'h3;
        `LMSC_SIZE_64_1234: devicesOf = 3'h4;
        default: devicesOf = 3'h3;
      endcase
    end
  endfunction

  // Scan slot of a device position for each stack size code
  function [2:0] slotOf;
    input [2:0] size;
    input [1:0] pos;
    begin
      case (size)
        `LMSC_SIZE_48_132, `LMSC_SIZE_4864_132:
          slotOf = (pos == 2'h1) ? 3'h2 : (pos == 2'h2) ? 3'h1 : {1'b0, pos};
        `LMSC_SIZE_64_143:
          slotOf = (pos == 2'h3) ? 3'h1 : (pos == 2'h2) ? 3'h2 : (pos == 2'h1) ? 3'h3 : 3'h0;
        default:
          slotOf = {1'b0, pos};
      endcase
    end
  endfunction

  // Decode of the current stack arrangement
  always @*
  begin
    devices_d = devicesOf(stackSize_q);
    slot_d = slotOf(stackSize_q, stackPos_q);
  end

  // Read mux, unmapped words read zero with an error response
  always @*
  begin
    mapped_d = 1'b1;
    readWord_d = 32'h0;
    case (avsAddress)
      `LMSC_OFS_STACK:
      begin
        readWord_d[`LMSC_STACK_SIZE_MSB:`LMSC_STACK_SIZE_LSB] = stackSize_q;
        readWord_d[`LMSC_STACK_REV_BIT] = scanReverse_q;
        readWord_d[`LMSC_STACK_POS_MSB:`LMSC_STACK_POS_LSB] = stackPos_q;
        readWord_d[`LMSC_STACK_LINES_MSB:`LMSC_STACK_LINES_LSB] = usedLines_q;
      end
      `LMSC_OFS_GAIN: readWord_d[2:0] = gainCode_q;
      `LMSC_OFS_COLOR: readWord_d = {8'h0, blueCode_q, greenCode_q, redCode_q};
      `LMSC_OFS_STATUS: readWord_d = {8'h0, 1'b0, matrixLine, 4'h0, stepIndex, 4'h0, owned_q, devices_d};
      `LMSC_OFS_ID: readWord_d = `LMSC_ID_VALUE;
      default: mapped_d = 1'b0;
    endcase
  end

  // Bus slave: request held with waitrequest high one cycle, answered the next
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      busState_q <= ST_IDLE;
      avsWaitrequest <= 1'b1;
      avsReaddata <= 32'h0;
      avsResponse <= 2'h0;
    end
    else if (ce)
    begin
      case (busState_q)
        ST_IDLE:
        begin
          avsWaitrequest <= 1'b1;
          if (avsRead | avsWrite)
          begin
            busState_q <= ST_ACK;
            avsWaitrequest <= 1'b0;
            avsReaddata <= avsRead ? readWord_d : 32'h0;
            avsResponse <= mapped_d ? 2'h0 : 2'h2;
          end
        end
        ST_ACK:
        begin
          busState_q <= ST_IDLE;
          avsWaitrequest <= 1'b1;
        end
        default:
        begin
          busState_q <= ST_IDLE;
          avsWaitrequest <= 1'b1;
        end
      endcase
    end
  end

  // Configuration registers, written when the request is accepted
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      stackSize_q <= `LMSC_SIZE_RST;
      scanReverse_q <= 1'b0;
      stackPos_q <= `LMSC_POS_RST;
      usedLines_q <= `LMSC_LINES_RST;
      gainCode_q <= `LMSC_GAIN_RST;
      redCode_q <= `LMSC_COLOR_RST;
      greenCode_q <= `LMSC_COLOR_RST;
      blueCode_q <= `LMSC_COLOR_RST;
    end
    else if (ce && busState_q == ST_IDLE && avsWrite)
    begin
      case (avsAddress)
        `LMSC_OFS_STACK:
        begin
          if (avsByteenable[0])
          begin
            stackSize_q <= avsWritedata[`LMSC_STACK_SIZE_MSB:`LMSC_STACK_SIZE_LSB];
            scanReverse_q <= avsWritedata[`LMSC_STACK_REV_BIT];
          end
          if (avsByteenable[1])
            stackPos_q <= avsWritedata[`LMSC_STACK_POS_MSB:`LMSC_STACK_POS_LSB];
          if (avsByteenable[2])
            usedLines_q <= avsWritedata[`LMSC_STACK_LINES_MSB:`LMSC_STACK_LINES_LSB];
        end
        `LMSC_OFS_GAIN:
          if (avsByteenable[0])
            gainCode_q <= avsWritedata[2:0];
        `LMSC_OFS_COLOR:
        begin
          if (avsByteenable[0])
            redCode_q <= avsWritedata[`LMSC_RED_MSB:`LMSC_RED_LSB];
          if (avsByteenable[1])
            greenCode_q <= avsWritedata[`LMSC_GRN_MSB:`LMSC_GRN_LSB];
          if (avsByteenable[2])
            blueCode_q <= avsWritedata[`LMSC_BLU_MSB:`LMSC_BLU_LSB];
        end
        default:
          stackSize_q <= stackSize_q;
      endcase
    end
  end

  // Turn counter across stacked devices, advanced on each local frame wrap
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      turn_q <= 3'h0;
      owned_q <= 1'b1;
    end
    else if (ce)
    begin
      if (devices_d == 3'h1)
        turn_q <= 3'h0;
      else if (lineAdvance && stepLast)
        turn_q <= (turn_q + 3'h1 >= devices_d) ? 3'h0 : turn_q + 3'h1;
      owned_q <= (devices_d == 3'h1) || (turn_q == slot_d);
    end
  end

  // Last line of a device section reached on this advance
  assign stepLast = ({1'b0, stepLine} + 5'h1 >= ((usedLines_q == 5'h0 || usedLines_q > 5'h10) ? 5'h10 : usedLines_q));

  lmsc_line_stepper u_stepper (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .enable(1'b1),
    .advance(lineAdvance),
    .reverse(scanReverse_q),
    .usedLines(usedLines_q),
    .rowSwitch(stepSwitch),
    .switchIndex(stepIndex),
    .lineIndex(stepLine),
    .frameWrap()
  );

  lmsc_gain_decode u_gainR (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .globalGainCode(gainCode_q),
    .colorCode(redCode_q),
    .gainHundredths(gainValue),
    .ratioNum(ratioR)
  );

  lmsc_gain_decode u_gainG (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .globalGainCode(gainCode_q),
    .colorCode(greenCode_q),
    .gainHundredths(),
    .ratioNum(ratioG)
  );

  lmsc_gain_decode u_gainB (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .globalGainCode(gainCode_q),
    .colorCode(blueCode_q),
    .gainHundredths(),
    .ratioNum(ratioB)
  );

  // Output stage: switch drive only while this device owns the scan turn
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rowSwitch <= 16'h0;
      matrixLine <= 7'h0;
      lineOwned <= 1'b0;
      globalGain <= `LMSC_GAIN_3;
      redRatio <= 9'h80;
      greenRatio <= 9'h80;
      blueRatio <= 9'h80;
      deviceCount <= 3'h1;
    end
    else if (ce)
    begin
      rowSwitch <= owned_q ? stepSwitch : 16'h0;
      matrixLine <= (devices_d == 3'h1 ? 7'h0 : {turn_q, 4'h0}) + {3'h0, stepLine};
      lineOwned <= owned_q;
      globalGain <= gainValue;
      redRatio <= ratioR;
      greenRatio <= ratioG;
      blueRatio <= ratioB;
      deviceCount <= devices_d;
    end
  end

endmodule

//--- verification/lmsc_props.sv
// Port checks for the stack and current block
`timescale 1ns/1ps
module lmsc_props (
  input wire clock,
  input wire rst,
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsReaddata,
  input wire avsWaitrequest,
  input wire [15:0] rowSwitch,
  input wire lineOwned,
  input wire [15:0] globalGain,
  input wire [8:0] redRatio,
  input wire [2:0] deviceCount
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Bus answers: bounded, one cycle long, data moves only then
  answer_bound_a: assert property ((avsRead || avsWrite) && avsWaitrequest |-> ##[0:3] !avsWaitrequest)
    else $error("answer late");
  answer_pulse_a: assert property (!avsWaitrequest |=> avsWaitrequest)
    else $error("answer too long");
  data_hold_a: assert property (!$stable(avsReaddata) |-> !avsWaitrequest)
    else $error("read data moved");
  // Row drive: one switch at most, none outside this device's turn
  row_onehot_a: assert property ($onehot0(rowSwitch))
    else $error("two switches on");
  row_owned_a: assert property (!lineOwned |-> rowSwitch == 16'h0000)
    else $error("switch on outside turn");
  // Decoded current codes and device count
  gain_table_a: assert property (globalGain inside {16'h0971, 16'h0bf1, 16'h1355, 16'h21d5, 16'h289a,
    16'h32c0, 16'h3a00, 16'h43ab}) else $error("gain off table");
  gain_reset_a: assert property ($fell(rst) |-> globalGain == 16'h21d5 && redRatio == 9'h080)
    else $error("bad reset codes");
  count_range_a: assert property (deviceCount != 3'h0 && deviceCount <= 3'h4)
    else $error("bad device count");
  cover property (avsWrite && !avsWaitrequest);
  cover property (avsRead && !avsWaitrequest);
  cover property ($rose(lineOwned));
endmodule
bind lmsc_stack_current lmsc_props i_props (.clock(clock), .rst(rst), .avsRead(avsRead), .avsWrite(avsWrite),
  .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .rowSwitch(rowSwitch), .lineOwned(lineOwned),
  .globalGain(globalGain), .redRatio(redRatio), .deviceCount(deviceCount));

//--- verification/lmsc_scan_partner.sv
// Scan side model: one step pulse per scan line at a chosen spacing
`timescale 1ns/1ps
module lmsc_scan_partner (
  input wire clock,
  input wire rst,
  input wire run,
  input wire [7:0] gap,
  output reg lineAdvance
);
  reg [7:0] count_q;
  // Count out the gap, pulse once when it runs out
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      count_q <= 8'h00;
      lineAdvance <= 1'b0;
    end
    else
    begin
      lineAdvance <= run && count_q == 8'h00;
      count_q <= (count_q == 8'h00 || !run) ? gap - 8'h01 : count_q - 8'h01;
    end
  end
endmodule

//--- verification/tb_top.sv
// Self-checking bench for the stack and current block
`timescale 1ns/1ps
`include "lmsc_regs.vh"
module tb_top;
  logic clock, rst, ce, avsRead, avsWrite, run;
  logic [2:0] avsAddress;
  logic [31:0] avsWritedata, q;
  logic [3:0] avsByteenable;
  logic [1:0] resp;
  wire [31:0] avsReaddata;
  wire avsWaitrequest, lineAdvance, lineOwned;
  wire [1:0] avsResponse;
  wire [15:0] rowSwitch, globalGain;
  wire [6:0] matrixLine;
  wire [8:0] redRatio, greenRatio, blueRatio;
  wire [2:0] deviceCount;
  int errors, comparisons;
  logic [15:0] gainTable [8] = '{16'h0971, 16'h0bf1, 16'h1355, 16'h21d5, 16'h289a, 16'h32c0, 16'h3a00, 16'h43ab};
  lmsc_stack_current i_dut (.clock(clock), .rst(rst), .ce(ce), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .avsResponse(avsResponse), .lineAdvance(lineAdvance), .rowSwitch(rowSwitch),
    .matrixLine(matrixLine), .lineOwned(lineOwned), .globalGain(globalGain), .redRatio(redRatio),
    .greenRatio(greenRatio), .blueRatio(blueRatio), .deviceCount(deviceCount));
  lmsc_scan_partner i_rows (.clock(clock), .rst(rst), .run(run), .gap(8'h06), .lineAdvance(lineAdvance));
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One bus access, held until the slave answers
  task automatic bus(input logic [2:0] a, input logic w, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clock);
    avsAddress <= a;
    avsWrite <= w;
    avsRead <= !w;
    avsWritedata <= d;
    avsByteenable <= be;
    @(posedge clock);
    while (avsWaitrequest !== 1'b0 && n < 50)
    begin
      @(posedge clock);
      n++;
    end
    if (n == 50)
      errors++;
    q = avsReaddata;
    resp = avsResponse;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask
  task automatic reset_values();
    check("gain", 32'h21d5, globalGain);
    check("red", 32'h080, redRatio);
    check("green", 32'h080, greenRatio);
    check("blue", 32'h080, blueRatio);
    check("devices", 32'h1, deviceCount);
    bus(`LMSC_OFS_COLOR, 1'b0, 32'h0, 4'hf);
    check("colour word", 32'h007f7f7f, q);
    bus(3'h5, 1'b1, 32'h7, 4'hf);
    bus(3'h5, 1'b0, 32'h0, 4'hf);
    check("unmapped data", 32'h0, q);
    check("unmapped resp", 32'h2, resp);
  endtask
  task automatic gain_steps();
    for (int i = 0; i < 8; i++)
    begin
      bus(`LMSC_OFS_GAIN, 1'b1, i, 4'hf);
      bus(`LMSC_OFS_GAIN, 1'b0, 32'h0, 4'hf);
      check("gain code", i, q);
      check("gain", gainTable[i], globalGain);
    end
  endtask
  // Extreme codes, then one byte lane alone
  task automatic colour_codes();
    bus(`LMSC_OFS_COLOR, 1'b1, 32'h0001ff00, 4'hf);
    bus(`LMSC_OFS_COLOR, 1'b0, 32'h0, 4'hf);
    check("red", 32'h001, redRatio);
    check("green", 32'h100, greenRatio);
    check("blue", 32'h002, blueRatio);
    bus(`LMSC_OFS_COLOR, 1'b1, 32'h00aaaaaa, 4'h2);
    bus(`LMSC_OFS_COLOR, 1'b0, 32'h0, 4'hf);
    check("colour word", 32'h0001aa00, q);
    check("green", 32'h0ab, greenRatio);
  endtask
  // White balance with the strongest group at full code, then mid-range gain
  task automatic white_balance();
    bus(`LMSC_OFS_GAIN, 1'b1, 32'h7, 4'hf);
    bus(`LMSC_OFS_COLOR, 1'b1, 32'h004c99ff, 4'hf);
    bus(`LMSC_OFS_COLOR, 1'b0, 32'h0, 4'hf);
    check("colour word", 32'h004c99ff, q);
    check("red", 32'h100, redRatio);
    check("green", 32'h09a, greenRatio);
    check("blue", 32'h04d, blueRatio);
    check("gain", gainTable[7], globalGain);
    bus(`LMSC_OFS_GAIN, 1'b1, 32'h4, 4'hf);
    bus(`LMSC_OFS_GAIN, 1'b0, 32'h0, 4'hf);
    check("gain", gainTable[4], globalGain);
    check("ok resp", 32'h0, resp);
  endtask
  // Clock enable low must hold the scan position while steps keep coming
  task automatic freeze();
    logic [6:0] held;
    logic [15:0] heldSwitch;
    @(posedge clock);
    run <= 1'b1;
    repeat (8) @(posedge clock);
    ce <= 1'b0;
    @(posedge clock);
    held = matrixLine;
    heldSwitch = rowSwitch;
    repeat (20) @(posedge clock);
    check("frozen line", held, matrixLine);
    check("frozen switch", heldSwitch, rowSwitch);
    ce <= 1'b1;
    run <= 1'b0;
  endtask
  task automatic size_codes();
    logic [2:0] expCount [8] = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h3, 3'h3, 3'h4, 3'h3};
    for (int i = 0; i < 8; i++)
    begin
      bus(`LMSC_OFS_STACK, 1'b1, 32'h00100000 | i, 4'hf);
      bus(`LMSC_OFS_STATUS, 1'b0, 32'h0, 4'hf);
      check("devices", expCount[i], deviceCount);
      check("status devices", expCount[i], q[2:0]);
    end
  endtask
  // Step the scan and judge switch, line and turn against the stack word
  task automatic scan(input logic [31:0] cfg, input logic [6:0] total, input int steps);
    logic [6:0] base, offs, prev;
    logic own;
    int n;
    base = {1'b0, cfg[9:8], 4'h0};
    bus(`LMSC_OFS_STACK, 1'b1, cfg, 4'hf);
    run <= 1'b1;
    for (int i = 0; i < steps; i++)
    begin
      n = 0;
      @(posedge clock);
      while (lineAdvance !== 1'b1 && n < 50)
      begin
        @(posedge clock);
        n++;
      end
      repeat (3) @(posedge clock);
      offs = matrixLine - base;
      own = matrixLine >= base && offs < 7'h10;
      if (i > 0)
        check("line", (prev + 7'h01) % total, matrixLine);
      check("owned", own, lineOwned);
      check("switch", own ? (cfg[4] ? 16'h8000 >> offs : 16'h0001 << offs) : 16'h0, rowSwitch);
      prev = matrixLine;
    end
    run <= 1'b0;
  endtask
  task automatic finish_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Clock
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Main sequence
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    avsAddress = 3'h0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWritedata = 32'h0;
    avsByteenable = 4'h0;
    run = 1'b0;
    errors = 0;
    comparisons = 0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    reset_values();
    gain_steps();
    colour_codes();
    white_balance();
    size_codes();
    scan(32'h00100000, 7'h10, 18);
    scan(32'h00100010, 7'h10, 18);
    scan(32'h000e0000, 7'h0e, 16);
    scan(32'h00100001, 7'h20, 34);
    scan(32'h00100111, 7'h20, 34);
    freeze();
    finish_test();
  end
  // Watchdog
  initial
  begin
    #100000;
    errors++;
    finish_test();
  end
endmodule
